// ==== logic/iotc_regs.vh ====
`ifndef IOTC_REGS_VH
`define IOTC_REGS_VH

// byte address of the tuning register on the register bus
`define IOTC_TUNING_ADDR      4'h0
`define IOTC_ADDR_W           4
// field layout of the tuning register
`define IOTC_SRC_SEL_BIT      7
`define IOTC_MULT_EN_BIT      6
`define IOTC_TRIM_MSB         5
`define IOTC_TRIM_LSB         0
`define IOTC_TRIM_W           6
`define IOTC_TUNING_W         8
// reset values
`define IOTC_TUNING_RST       8'h00
`define IOTC_TRIM_RST         6'h00
// axi responses
`define IOTC_RESP_OKAY        2'h0
`define IOTC_RESP_SLVERR      2'h2

`endif

// ==== logic/iotc_top.v ====
// Implementation choices: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ps
`include "iotc_regs.vh"

module iotc_top (
  input  wire        clk_sys_i,        // system clock, 100 MHz
  input  wire        nrst_i,           // async reset, active low
  input  wire        clk_en_i,         // clock enable, freezes state when low
  input  wire [3:0]  s_axi_awaddr_i,   // write address
  input  wire        s_axi_awvalid_i,  // write address valid
  output reg         s_axi_awready_o,  // write address ready
  input  wire [31:0] s_axi_wdata_i,    // write data
  input  wire [3:0]  s_axi_wstrb_i,    // write byte strobes
  input  wire        s_axi_wvalid_i,   // write data valid
  output reg         s_axi_wready_o,   // write data ready
  output reg  [1:0]  s_axi_bresp_o,    // write response
  output reg         s_axi_bvalid_o,   // write response valid
  input  wire        s_axi_bready_i,   // write response ready
  input  wire [3:0]  s_axi_araddr_i,   // read address
  input  wire        s_axi_arvalid_i,  // read address valid
  output reg         s_axi_arready_o,  // read address ready
  output reg  [31:0] s_axi_rdata_o,    // read data
  output reg  [1:0]  s_axi_rresp_o,    // read response
  output reg         s_axi_rvalid_o,   // read data valid
  input  wire        s_axi_rready_i,   // read data ready
  output reg  [5:0]  trim_code_o,      // signed trim to fast oscillator
  output reg         low_freq_source_select_o, // 31 kHz source choice
  output reg         multiplier_enable_o       // 4x multiplier enable
);

  // one-hot states shared by the write address and write data channels
  localparam [2:0] CH_IDLE  = 3'b001;  // ready low, nothing held
  localparam [2:0] CH_OFFER = 3'b010;  // ready high for this cycle only
  localparam [2:0] CH_HELD  = 3'b100;  // item taken, waits for the commit
  // one-hot states of the read channel
  localparam [2:0] RD_IDLE  = 3'b001;  // arready low, nothing pending
  localparam [2:0] RD_ADDR  = 3'b010;  // arready high for this cycle only
  localparam [2:0] RD_DATA  = 3'b100;  // rvalid stands until rready
  localparam       NUM_WCH  = 2;       // write address and write data

  // clock enable low freezes every flop below, bus handshakes included,
  // so a master must not count on progress while it is low
  reg  [`IOTC_ADDR_W-1:0]   aw_addr_q;
  reg  [`IOTC_TUNING_W-1:0] w_data_q;
  reg                       w_byte0_q;
  reg  [2:0]                rd_state_q;
  reg  [2:0]                rd_state_d;
  wire [NUM_WCH-1:0]        ch_valid;
  wire [NUM_WCH-1:0]        ch_held;
  wire [NUM_WCH-1:0]        ch_offer_d;
  wire                      aw_take;
  wire                      w_take;
  wire                      commit;
  wire                      load_tuning;
  wire                      ar_take;
  wire                      wr_hit;
  wire                      rd_hit;
  wire [`IOTC_TUNING_W-1:0] tuning_now;
  wire [`IOTC_TUNING_W-1:0] tuning_d;

  assign ch_valid    = {s_axi_wvalid_i, s_axi_awvalid_i};
  assign aw_take     = s_axi_awvalid_i & s_axi_awready_o;
  assign w_take      = s_axi_wvalid_i & s_axi_wready_o;
  // address and data may arrive in either order; commit once both are
  // held and the previous response has been accepted
  assign commit      = ch_held[0] & ch_held[1] & ~s_axi_bvalid_o;
  assign wr_hit      = (aw_addr_q == `IOTC_TUNING_ADDR);
  // a cleared lane-0 strobe still answers okay but leaves the bits alone
  assign load_tuning = commit & wr_hit & w_byte0_q;
  assign ar_take     = s_axi_arvalid_i & s_axi_arready_o;
  assign rd_hit      = (s_axi_araddr_i == `IOTC_TUNING_ADDR);
  // read back straight from the output flops, no shadow copy to drift
  assign tuning_now  = {low_freq_source_select_o, multiplier_enable_o,
                        trim_code_o};

  // both write channels run the same ready/hold cycle; ready is offered
  // every other idle cycle so that it can come straight from a flop
  genvar ch;
  generate
    for (ch = 0; ch < NUM_WCH; ch = ch + 1) begin : g_wch
      reg [2:0] state_q;
      reg [2:0] state_d;

      always @* begin
        state_d = state_q;
        case (state_q)
          CH_IDLE: begin
            state_d = CH_OFFER;
          end
          CH_OFFER: begin
            // ready is high now: valid means the item is taken
            state_d = ch_valid[ch] ? CH_HELD : CH_IDLE;
          end
          CH_HELD: begin
            // refuse a second item until this one is committed
            state_d = commit ? CH_IDLE : CH_HELD;
          end
          default: begin
            state_d = CH_IDLE;
          end
        endcase
      end

      always @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
          state_q <= CH_IDLE;
        end else if (clk_en_i) begin
          state_q <= state_d;
        end
      end

      assign ch_held[ch]    = state_q[2];
      assign ch_offer_d[ch] = state_d[1];
    end
  endgenerate

  // ready outputs mirror the offer state of each channel
  always @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s_axi_awready_o <= 1'b0;
      s_axi_wready_o  <= 1'b0;
    end else if (clk_en_i) begin
      s_axi_awready_o <= ch_offer_d[0];
      s_axi_wready_o  <= ch_offer_d[1];
    end
  end

  // write payload; only byte lane 0 carries register bits, the upper
  // lanes and their strobes are ignored
  always @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      aw_addr_q <= 4'h0;
      w_data_q  <= `IOTC_TUNING_RST;
      w_byte0_q <= 1'b0;
    end else if (clk_en_i) begin
      if (aw_take) begin
        aw_addr_q <= s_axi_awaddr_i;
      end
      if (w_take) begin
        w_data_q  <= s_axi_wdata_i[`IOTC_TUNING_W-1:0];
        w_byte0_q <= s_axi_wstrb_i[0];
      end
    end
  end

  // write response; an unmapped address is refused with slverr and
  // writes nothing
  always @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o  <= `IOTC_RESP_OKAY;
    end else if (clk_en_i) begin
      if (commit) begin
        s_axi_bvalid_o <= 1'b1;
        s_axi_bresp_o  <= wr_hit ? `IOTC_RESP_OKAY : `IOTC_RESP_SLVERR;
      end else if (s_axi_bvalid_o && s_axi_bready_i) begin
        s_axi_bvalid_o <= 1'b0;
      end
    end
  end

  // next value of each register bit; all eight bits are plain read/write
  // storage, so one loop covers them
  genvar b;
  generate
    for (b = 0; b < `IOTC_TUNING_W; b = b + 1) begin : g_bit
      assign tuning_d[b] = load_tuning ? w_data_q[b] : tuning_now[b];
    end
  endgenerate

  // register bits are the output flops themselves: the new trim reaches
  // the oscillator on the same edge that raises bvalid
  always @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      trim_code_o              <= `IOTC_TRIM_RST;
      multiplier_enable_o      <= 1'b0;
      low_freq_source_select_o <= 1'b0;
    end else if (clk_en_i) begin
      // the analog side then slews with no completion flag to software
      // trim feeds the fast oscillator only, never the slow one
      trim_code_o <= tuning_d[`IOTC_TRIM_MSB:`IOTC_TRIM_LSB];
      multiplier_enable_o <= tuning_d[`IOTC_MULT_EN_BIT];
      low_freq_source_select_o <= tuning_d[`IOTC_SRC_SEL_BIT];
    end
  end

  // read channel: one read at a time, no new address while rvalid stands
  always @* begin
    rd_state_d = rd_state_q;
    case (rd_state_q)
      RD_IDLE: begin
        rd_state_d = RD_ADDR;
      end
      RD_ADDR: begin
        rd_state_d = s_axi_arvalid_i ? RD_DATA : RD_IDLE;
      end
      RD_DATA: begin
        rd_state_d = s_axi_rready_i ? RD_IDLE : RD_DATA;
      end
      default: begin
        rd_state_d = RD_IDLE;
      end
    endcase
  end

  // read data is captured when the address is taken and then stands
  always @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rd_state_q      <= RD_IDLE;
      s_axi_arready_o <= 1'b0;
      s_axi_rvalid_o  <= 1'b0;
      s_axi_rresp_o   <= `IOTC_RESP_OKAY;
      s_axi_rdata_o   <= 32'h0000_0000;
    end else if (clk_en_i) begin
      rd_state_q      <= rd_state_d;
      s_axi_arready_o <= rd_state_d[1];
      s_axi_rvalid_o  <= rd_state_d[2];
      if (ar_take) begin
        s_axi_rresp_o <= rd_hit ? `IOTC_RESP_OKAY : `IOTC_RESP_SLVERR;
        s_axi_rdata_o <= rd_hit ? {24'h00_0000, tuning_now} : 32'h0000_0000;
      end
    end
  end

endmodule

// ==== dv/iotc_props.sv ====
`timescale 1ns/1ps
module iotc_props (
  input logic        clk_sys_i,                // system clock
  input logic        nrst_i,                   // async reset, active low
  input logic        s_axi_wvalid_i,           // write data valid
  input logic        s_axi_wready_o,           // write data ready
  input logic        s_axi_bvalid_o,           // write response valid
  input logic        s_axi_bready_i,           // write response ready
  input logic        s_axi_arvalid_i,          // read address valid
  input logic        s_axi_arready_o,          // read address ready
  input logic        s_axi_rvalid_o,           // read data valid
  input logic        s_axi_rready_i,           // read data ready
  input logic [31:0] s_axi_rdata_o,            // read data
  input logic [1:0]  s_axi_rresp_o,            // read response
  input logic [5:0]  trim_code_o,              // trim output
  input logic        low_freq_source_select_o, // source select output
  input logic        multiplier_enable_o       // multiplier enable output
);
  wire [7:0] tun = {low_freq_source_select_o, multiplier_enable_o,
                    trim_code_o};
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!nrst_i);
  sequence w_take; s_axi_wvalid_i && s_axi_wready_o; endsequence
  sequence ar_take; s_axi_arvalid_i && s_axi_arready_o; endsequence
  chk_outputs_held: assert property (
    !$rose(s_axi_bvalid_o) |-> $stable(tun)) else $error("outputs moved");
  chk_reset_zero: assert property (
    $rose(nrst_i) |-> tun == 8'h00) else $error("reset value");
  chk_write_answer: assert property (
    w_take |-> ##[1:3] s_axi_bvalid_o) else $error("no write answer");
  chk_bvalid_held: assert property (
    s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o) else $error("b");
  chk_read_answer: assert property (
    ar_take |=> s_axi_rvalid_o) else $error("no read answer");
  chk_rdata_held: assert property (
    s_axi_rvalid_o && !s_axi_rready_i |=> $stable(s_axi_rdata_o))
    else $error("rdata moved");
  chk_upper_zero: assert property (
    s_axi_rvalid_o |-> s_axi_rdata_o[31:8] == 24'h0) else $error("upper");
  chk_read_value: assert property (
    $rose(s_axi_rvalid_o) && s_axi_rresp_o == 2'h0 |->
    s_axi_rdata_o[7:0] == tun) else $error("read value");
endmodule
bind iotc_top iotc_props u_props (.*);

// ==== dv/iotc_top_tb.sv ====
`timescale 1ns/1ps
`include "iotc_regs.vh"
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin \
  mismatches++; $display("[FAIL] %s exp %h got %h", n, e, g); end end
module iotc_top_tb;
  logic clk_sys_i = 0, nrst_i = 0, clk_en_i = 1, s_axi_awvalid_i = 0,
    s_axi_wvalid_i = 0, s_axi_bready_i = 0, s_axi_arvalid_i = 0,
    s_axi_rready_i = 0, s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o,
    s_axi_arready_o, s_axi_rvalid_o, low_freq_source_select_o,
    multiplier_enable_o;
  logic [3:0] s_axi_awaddr_i = 0, s_axi_araddr_i = 0, s_axi_wstrb_i = 0;
  logic [31:0] s_axi_wdata_i = 0, s_axi_rdata_o;
  logic [1:0] s_axi_bresp_o, s_axi_rresp_o;
  logic [5:0] trim_code_o;
  int mismatches = 0, compares = 0;
  iotc_top dut (.*);
  initial forever #5 clk_sys_i = ~clk_sys_i;
  task end_sim;
    $display("mismatches %0d compares %0d", mismatches, compares);
    if (mismatches == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic wr(input [3:0] a, s, input [7:0] d, input [1:0] r);
    @(posedge clk_sys_i);
    s_axi_awaddr_i <= a;
    s_axi_wstrb_i <= s;
    s_axi_wdata_i <= {24'h0, d};
    s_axi_awvalid_i <= 1;
    s_axi_wvalid_i <= 1;
    s_axi_bready_i <= 1;
    do begin
      @(posedge clk_sys_i);
      if (s_axi_awready_o) s_axi_awvalid_i <= 0;
      if (s_axi_wready_o) s_axi_wvalid_i <= 0;
    end while (!s_axi_bvalid_o);
    `CHK("bresp", r, s_axi_bresp_o)
    s_axi_bready_i <= 0;
  endtask
  task automatic rd(input [3:0] a, input [7:0] e, input [1:0] r);
    @(posedge clk_sys_i);
    s_axi_araddr_i <= a;
    s_axi_arvalid_i <= 1;
    s_axi_rready_i <= 1;
    do begin
      @(posedge clk_sys_i);
      if (s_axi_arready_o) s_axi_arvalid_i <= 0;
    end while (!s_axi_rvalid_o);
    `CHK("rdata", {24'h0, e}, s_axi_rdata_o)
    `CHK("rresp", r, s_axi_rresp_o)
    s_axi_rready_i <= 0;
  endtask
  task automatic outs(input [7:0] e);
    logic [7:0] g;
    g = {low_freq_source_select_o, multiplier_enable_o, trim_code_o};
    `CHK("outs", e, g)
  endtask
  task automatic t_freeze;
    logic a0;
    // idle ready toggles every cycle, so a frozen block must hold it still
    wr(`IOTC_TUNING_ADDR, 4'h1, 8'h2a, `IOTC_RESP_OKAY);
    @(posedge clk_sys_i);
    clk_en_i <= 0;
    @(posedge clk_sys_i);
    a0 = s_axi_awready_o;
    repeat (3) @(posedge clk_sys_i);
    `CHK("awready frozen", a0, s_axi_awready_o)
    outs(8'h2a);
    clk_en_i <= 1;
    rd(`IOTC_TUNING_ADDR, 8'h2a, `IOTC_RESP_OKAY);
  endtask
  task automatic t_fields;
    // extremes of the signed trim plus each control bit alone
    logic [7:0] v[5] = '{8'h80, 8'h40, 8'h20, 8'h1f, 8'hff};
    foreach (v[i]) begin
      wr(`IOTC_TUNING_ADDR, 4'hf, v[i], `IOTC_RESP_OKAY);
      outs(v[i]);
      rd(`IOTC_TUNING_ADDR, v[i], `IOTC_RESP_OKAY);
    end
  endtask
  task automatic t_refuse;
    wr(4'h4, 4'hf, 8'h00, `IOTC_RESP_SLVERR);
    rd(4'h8, 8'h00, `IOTC_RESP_SLVERR);
    wr(`IOTC_TUNING_ADDR, 4'he, 8'h00, `IOTC_RESP_OKAY);
    outs(8'hff);
    nrst_i <= 0;
    @(posedge clk_sys_i);
    outs(8'h00);
    nrst_i <= 1;
    rd(`IOTC_TUNING_ADDR, 8'h00, `IOTC_RESP_OKAY);
  endtask
  initial begin
    repeat (3) @(posedge clk_sys_i);
    nrst_i <= 1;
    outs(8'h00);
    t_fields();
    t_refuse();
    t_freeze();
    end_sim();
  end
  initial begin
    #20000;
    mismatches++;
    end_sim();
  end
endmodule
